// file: eewr_pkg.sv
package eewr_pkg;

  // client address code in the top nibble of the control byte
  localparam logic [3:0] CTRL_CODE = 4'ha;

  // bit counter values within one byte
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_TOP = 4'h7;
  localparam logic [3:0] BIT_CNT_LAST = 4'h8;

  // array and page geometry
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 8;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [2:0] PAGE_STEP = 3'h1;
  localparam logic [7:0] WORD_STEP = 8'h01;

  // internal write cycle, longest time rounded down to whole cycles
  localparam longint SYS_CLK_PERIOD_NS = 20;
  localparam longint WRITE_CYCLE_MS = 5;
  localparam longint NS_PER_MS = 1000000;
  localparam int WRITE_CYCLES = int'((WRITE_CYCLE_MS * NS_PER_MS) / SYS_CLK_PERIOD_NS);
  localparam int WCNT_W = 18;
  localparam logic [WCNT_W-1:0] WCNT_RST = 18'h00000;
  localparam logic [WCNT_W-1:0] WCNT_STEP = 18'h00001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } eewr_state_type;

  // pin levels taken into the link domain together
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic en;
  } eewr_pins_type;

  // bus idle, write protect off, clock enable off until sampled
  localparam eewr_pins_type PINS_RST = 4'b1100;

endpackage

// file: eewr_client.sv
`timescale 1ns/1ns
// How it works
// - data changes only while clock low
// - falling data, clock high starts transaction
// - rising data, clock high ends transaction
// - one clock pulse per bit, sampled high
// - acknowledge slot follows every eight bits
// - acknowledger holds data low through pulse
// - host nack ends read, line released
// - top nibble must match client code
// - control bit zero writes, one reads
// - matching control byte is acknowledged
// - next write byte loads address pointer
// - byte write: control, address, data, stop
// - stop after write starts internal cycle
// - no acknowledge while write cycle runs
// - up to eight bytes buffered until stop
// - data bytes step low three pointer bits
// - over eight bytes wrap and overwrite
// - write protect high blocks all programming
// - pointer holds last accessed plus one
// - repeated start after address writes nothing
// - host ack advances to next byte
module eewr_client #(
  parameter int P_WRITE_CYCLES = eewr_pkg::WRITE_CYCLES
) (
  // system clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // link clock sampling the bus
  input wire logic i_link_clk,
  // two-wire bus and write protect
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  output logic o_sda_out,
  output logic o_sda_oe,
  // status
  output logic o_busy
);

  eewr_pkg::eewr_pins_type pin_s1_reg;
  eewr_pkg::eewr_pins_type pin_s2_reg;
  eewr_pkg::eewr_pins_type pin_d_reg;
  eewr_pkg::eewr_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_phase_reg;
  logic host_nack_reg;
  logic sda_low_reg;
  logic write_pend_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] page_reg [eewr_pkg::PAGE_BYTES];
  logic [eewr_pkg::PAGE_BYTES-1:0] valid_reg;
  logic [7:0] mem_reg [eewr_pkg::MEM_WORDS];
  logic req_tgl_reg;
  logic done_s1_reg;
  logic done_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic done_tgl_reg;
  logic counting_reg;
  logic [eewr_pkg::WCNT_W-1:0] wcnt_reg;
  logic [eewr_pkg::WCNT_W-1:0] wcnt_last;
  logic en_l;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic byte_end;
  logic ack_end;
  logic busy_l;
  logic commit;

  function automatic logic [7:0] eewr_addr_inc(input logic [7:0] a, input logic page_wrap);
    if (page_wrap) begin
      return {a[7:3], a[2:0] + eewr_pkg::PAGE_STEP};
    end
    return a + eewr_pkg::WORD_STEP;
  endfunction

  // page slot that a data byte lands in
  function automatic logic [2:0] eewr_slot(input logic [7:0] a);
    return a[2:0];
  endfunction

  // open drain: pull for a zero, release for a one
  function automatic logic eewr_pull(input logic [7:0] d, input logic [3:0] sent);
    return ~d[3'(eewr_pkg::BIT_CNT_TOP - sent)];
  endfunction

  // sda edge under a steady high scl; falling is a start, rising a stop
  function automatic logic eewr_cond(input eewr_pkg::eewr_pins_type now,
    input eewr_pkg::eewr_pins_type was, input logic rising);
    return now.scl && was.scl && (now.sda == rising) && (was.sda != rising);
  endfunction

  // pins come from outside, two flops before any logic looks at them
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_reg <= eewr_pkg::PINS_RST;
      pin_s2_reg <= eewr_pkg::PINS_RST;
      pin_d_reg <= eewr_pkg::PINS_RST;
    end else begin
      pin_s1_reg <= {i_scl, i_sda, i_wp, i_clk_en};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
    end
  end

  assign en_l = pin_s2_reg.en;
  assign start_det = en_l && eewr_cond(pin_s2_reg, pin_d_reg, 1'b0);
  assign stop_det = en_l && eewr_cond(pin_s2_reg, pin_d_reg, 1'b1);
  assign scl_rise = en_l && pin_s2_reg.scl && !pin_d_reg.scl;
  assign scl_fall = en_l && !pin_s2_reg.scl && pin_d_reg.scl;
  assign byte_end = scl_fall && !ack_phase_reg && (bit_cnt_reg == eewr_pkg::BIT_CNT_LAST);
  assign ack_end = scl_fall && ack_phase_reg;
  // busy spans the whole round trip, so no early ack can slip in
  assign busy_l = req_tgl_reg != done_s2_reg;
  assign commit = stop_det && write_pend_reg && !pin_s2_reg.wp && !busy_l;
  assign wcnt_last = eewr_pkg::WCNT_W'(P_WRITE_CYCLES - 1);

  // bus protocol
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= eewr_pkg::ST_IDLE;
      bit_cnt_reg <= eewr_pkg::BIT_CNT_RST;
      ack_phase_reg <= 1'b0;
      host_nack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      write_pend_reg <= 1'b0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= eewr_pkg::PTR_RST;
    end else if (en_l) begin
      if (start_det) begin
        // a repeated start drops pending data, pointer stays
        state_reg <= eewr_pkg::ST_CTRL;
        bit_cnt_reg <= eewr_pkg::BIT_CNT_RST;
        ack_phase_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        write_pend_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= eewr_pkg::ST_IDLE;
        bit_cnt_reg <= eewr_pkg::BIT_CNT_RST;
        ack_phase_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        write_pend_reg <= 1'b0;
      end else if (scl_rise) begin
        if (ack_phase_reg) begin
          host_nack_reg <= pin_s2_reg.sda;
        end else if (bit_cnt_reg != eewr_pkg::BIT_CNT_LAST) begin
          shift_reg <= {shift_reg[6:0], pin_s2_reg.sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (byte_end) begin
        ack_phase_reg <= 1'b1;
        unique case (state_reg)
          eewr_pkg::ST_CTRL: begin
            if (shift_reg[7:4] == eewr_pkg::CTRL_CODE && !busy_l) begin
              sda_low_reg <= 1'b1;
              host_nack_reg <= 1'b0;
              state_reg <= shift_reg[0] ? eewr_pkg::ST_RDATA : eewr_pkg::ST_ADDR;
            end else begin
              sda_low_reg <= 1'b0;
              state_reg <= eewr_pkg::ST_IGNORE;
            end
          end
          eewr_pkg::ST_ADDR: begin
            ptr_reg <= shift_reg;
            sda_low_reg <= 1'b1;
            state_reg <= eewr_pkg::ST_WDATA;
          end
          eewr_pkg::ST_WDATA: begin
            ptr_reg <= eewr_addr_inc(ptr_reg, 1'b1);
            sda_low_reg <= 1'b1;
            write_pend_reg <= 1'b1;
          end
          eewr_pkg::ST_RDATA: begin
            sda_low_reg <= 1'b0;
          end
          eewr_pkg::ST_IDLE, eewr_pkg::ST_IGNORE: begin
            sda_low_reg <= 1'b0;
          end
          default: begin
            sda_low_reg <= 1'b0;
            state_reg <= eewr_pkg::ST_IGNORE;
          end
        endcase
      end else if (ack_end) begin
        ack_phase_reg <= 1'b0;
        bit_cnt_reg <= eewr_pkg::BIT_CNT_RST;
        if (state_reg == eewr_pkg::ST_RDATA && !host_nack_reg) begin
          tx_reg <= mem_reg[ptr_reg];
          ptr_reg <= eewr_addr_inc(ptr_reg, 1'b0);
          sda_low_reg <= eewr_pull(mem_reg[ptr_reg], eewr_pkg::BIT_CNT_RST);
        end else begin
          sda_low_reg <= 1'b0;
          if (state_reg == eewr_pkg::ST_RDATA) begin
            state_reg <= eewr_pkg::ST_IGNORE;
          end
        end
      end else if (scl_fall && state_reg == eewr_pkg::ST_RDATA && !ack_phase_reg) begin
        sda_low_reg <= eewr_pull(tx_reg, bit_cnt_reg);
      end
    end
  end

  // page buffer, later bytes replace earlier ones at the same slot
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_reg <= '0;
      for (int i = 0; i < eewr_pkg::PAGE_BYTES; i++) begin
        page_reg[i] <= 8'h00;
      end
    end else if (en_l) begin
      if (start_det || stop_det) begin
        valid_reg <= '0;
      end else if (byte_end && state_reg == eewr_pkg::ST_WDATA) begin
        page_reg[eewr_slot(ptr_reg)] <= shift_reg;
        valid_reg[eewr_slot(ptr_reg)] <= 1'b1;
      end
    end
  end

  // array is programmed at the stop, the timer then only models busy
  always_ff @(posedge i_link_clk) begin
    if (en_l && commit) begin
      for (int i = 0; i < eewr_pkg::PAGE_BYTES; i++) begin
        if (valid_reg[i]) begin
          mem_reg[{ptr_reg[7:3], 3'(i)}] <= page_reg[i];
        end
      end
    end
  end

  // write cycle request and its completion crossing back
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_tgl_reg <= 1'b0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_tgl_reg;
      done_s2_reg <= done_s1_reg;
      if (en_l && commit) begin
        req_tgl_reg <= ~req_tgl_reg;
      end
    end
  end

  // write request crossing in, kept live so a toggle is never missed
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
    end
  end

  // internal write cycle timer, frozen with the enable low
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_tgl_reg <= 1'b0;
      counting_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (!counting_reg && req_s2_reg != done_tgl_reg) begin
        counting_reg <= 1'b1;
      end else if (counting_reg && wcnt_reg == wcnt_last) begin
        counting_reg <= 1'b0;
        done_tgl_reg <= ~done_tgl_reg;
      end
    end
  end

  // cycle count of the running write, parked at zero while idle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wcnt_reg <= eewr_pkg::WCNT_RST;
    end else if (i_clk_en) begin
      if (!counting_reg) begin
        wcnt_reg <= eewr_pkg::WCNT_RST;
      end else if (wcnt_reg != wcnt_last) begin
        wcnt_reg <= wcnt_reg + eewr_pkg::WCNT_STEP;
      end
    end
  end

  // open drain: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_low_reg;
  assign o_busy = counting_reg;

endmodule

// file: eewr_client_monitor.sv
`timescale 1ns/1ns
module eewr_client_monitor #(
  parameter int P_WRITE_CYCLES = 20
) (
  // clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_link_clk,
  input wire logic i_nrst,
  // pins
  input wire logic i_clk_en,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  // sized for the full-length timer
  logic [17:0] bcnt_reg;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bcnt_reg <= '0;
    end else if (!o_busy) begin
      bcnt_reg <= '0;
    end else begin
      bcnt_reg <= bcnt_reg + 18'h00001;
    end
  end
  drive_low_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    !o_sda_out) else $error("sda out high");
  oe_moves_low_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl)) else $error("oe moved, scl high");
  ack_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    $rose(i_scl) && o_sda_oe |-> o_sda_oe [*6]) else $error("oe dropped, scl high");
  release_late_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    $fell(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2)) else $error("early release");
  start_quiet_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    i_scl && $past(i_scl) && $fell(i_sda) |-> !o_sda_oe) else $error("oe at start");
  busy_no_ack_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_busy |-> !o_sda_oe) else $error("ack while busy");
  busy_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $fell(o_busy) |-> bcnt_reg >= 18'(P_WRITE_CYCLES - 1)
      && bcnt_reg <= 18'(P_WRITE_CYCLES + 1)) else $error("busy length");
  busy_wp_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(o_busy) |-> !i_wp) else $error("busy while protected");
  cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_busy));
  cover property (@(posedge i_link_clk) disable iff (!i_nrst) $rose(o_sda_oe));
  cover property (@(posedge i_link_clk) disable iff (!i_nrst) i_wp && $rose(o_sda_oe));
endmodule
bind eewr_client eewr_client_monitor #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) i_eewr_client_monitor (
  .i_sys_clk(i_sys_clk), .i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
  .i_scl(i_scl), .i_sda(i_sda), .i_wp(i_wp), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_busy(o_busy));

// file: eewr_host.sv
`timescale 1ns/1ns
module eewr_host (
  // pacing clock and resolved line
  input wire logic i_sys_clk,
  input wire logic i_sda,
  // host pins, high means released
  output logic o_scl = 1'h1,
  output logic o_sda = 1'h1
);
  // phases of 3 cycles so the sampler sees every edge
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'h0;
    @(posedge i_sys_clk) o_sda <= b;
    repeat (2) @(posedge i_sys_clk);
    o_scl <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    r = i_sda;
  endtask
  // s low gives a start, s high a stop
  task automatic bus_cond(input logic s);
    logic r;
    bit_io(!s, r);
    o_sda <= s;
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, r);
    k = !r;
  endtask
endmodule

// file: eewr_client_tb_top.sv
`timescale 1ns/1ns
module eewr_client_tb_top;
  // short timer, still long enough to poll inside it
  localparam int P_CYC = 200;
  logic i_sys_clk = 1'h0;
  logic i_link_clk = 1'h0;
  logic i_nrst = 1'h0;
  logic i_wp = 1'h0;
  logic scl;
  logic host_sda;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic sda;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  // pull-up: low only while a party pulls
  assign sda = host_sda & ~(sda_oe & ~sda_out);
  always #10 i_sys_clk = ~i_sys_clk;
  // offset keeps rising link edges off the rising system edges
  initial begin
    #2;
    forever #3 i_link_clk = ~i_link_clk;
  end
  eewr_client #(.P_WRITE_CYCLES(P_CYC)) i_eewr_client (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_clk_en(1'h1), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda), .i_wp(i_wp),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
  eewr_host i_eewr_host (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cond(input logic s);
    i_eewr_host.bus_cond(s);
  endtask
  task automatic tx(input logic [7:0] d, input logic ek);
    logic [7:0] q;
    logic k;
    i_eewr_host.byte_io(d, 1'h1, q, k);
    check_bit(k, ek);
  endtask
  task automatic rx(input logic more, input logic [7:0] eq);
    logic [7:0] q;
    logic k;
    i_eewr_host.byte_io(8'hff, !more, q, k);
    check_byte(q, eq);
  endtask
  task automatic wr_head(input logic [7:0] a);
    cond(1'h0);
    tx(8'ha0, 1'h1);
    tx(a, 1'h1);
  endtask
  task automatic read_at(input logic [7:0] a, input logic [7:0] eq);
    wr_head(a);
    cond(1'h0);
    tx(8'ha1, 1'h1);
    rx(1'h0, eq);
    cond(1'h1);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2 * P_CYC && busy !== 1'h0; i++) begin
      @(posedge i_sys_clk);
    end
    check_bit(busy, 1'h0);
  endtask
  task automatic t_byte;
    wr_head(8'h13);
    tx(8'h5a, 1'h1);
    cond(1'h1);
    check_bit(busy, 1'h1);
    cond(1'h0);
    tx(8'ha0, 1'h0);
    cond(1'h1);
    wait_idle();
    read_at(8'h13, 8'h5a);
    $display("done byte write");
  endtask
  task automatic t_codes;
    logic [7:0] c [5] = '{8'ha0, 8'hae, 8'h20, 8'hb0, 8'he0};
    foreach (c[i]) begin
      cond(1'h0);
      tx(c[i], c[i][7:4] == eewr_pkg::CTRL_CODE);
      tx(8'h00, c[i][7:4] == eewr_pkg::CTRL_CODE);
    end
    cond(1'h1);
    check_bit(busy, 1'h0);
    $display("done codes");
  endtask
  task automatic t_page;
    wr_head(8'h2e);
    for (int i = 0; i < 10; i++) begin
      tx(8'h10 + 8'(i), 1'h1);
    end
    cond(1'h1);
    wait_idle();
    wr_head(8'h28);
    cond(1'h0);
    tx(8'ha1, 1'h1);
    for (int i = 0; i < 7; i++) begin
      rx(i < 6, 8'h12 + 8'(i));
    end
    cond(1'h1);
    cond(1'h0);
    tx(8'ha1, 1'h1);
    rx(1'h0, 8'h19);
    cond(1'h1);
    $display("done page");
  endtask
  task automatic t_protect;
    i_wp <= 1'h1;
    wr_head(8'h13);
    tx(8'hff, 1'h1);
    cond(1'h1);
    check_bit(busy, 1'h0);
    read_at(8'h13, 8'h5a);
    i_wp <= 1'h0;
    $display("done protect");
  endtask
  task automatic finish_test;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'h1;
    repeat (4) @(posedge i_sys_clk);
    t_byte();
    t_codes();
    t_page();
    t_protect();
    finish_test();
  end
endmodule
